/* File: hw/trir_pkg.sv */
package trir_pkg;

   // ****************************************************************
   // Register map and flag layout
   // ****************************************************************
   localparam logic [7:0] ADDR_INFO_ONE   = 8'h22;
   localparam logic [7:0] ADDR_INFO_TWO   = 8'h31;
   localparam logic [7:0] ADDR_INFO_THREE = 8'h10;
   localparam logic [7:0] INFO_RESET      = 8'h00;
   localparam logic [7:0] RDATA_UNMAPPED  = 8'h00;

   // Positions in the 24-bit flag vector (three registers, low first)
   localparam int ALIGN_CHANGE_BIT   = 7;
   localparam int EIGHT_ZERO_BIT     = 6;
   localparam int SIXTEEN_ZERO_BIT   = 5;
   localparam int RX_STORE_FULL_BIT  = 4;
   localparam int RX_STORE_EMPTY_BIT = 3;
   localparam int SEVERE_FRAME_BIT   = 2;
   localparam int CODE_WORD_BIT      = 1;
   localparam int FRAMING_ERR_BIT    = 0;
   localparam int SYNC_RECOVER_BIT   = 15;
   localparam int CARRIER_RESTORE_BIT = 14;
   localparam int TX_STORE_FULL_BIT  = 13;
   localparam int TX_STORE_EMPTY_BIT = 12;
   localparam int TX_SLIP_BIT        = 11;
   localparam int ALL_ONES_CLR_BIT   = 10;
   localparam int RX_DENSITY_BIT     = 9;
   localparam int TX_DENSITY_BIT     = 8;
   localparam int LEVEL_HI_BIT       = 23;
   localparam int LEVEL_LO_BIT       = 22;
   localparam int JITTER_LIMIT_BIT   = 21;
   localparam int RX_CLK_LOSS_BIT    = 20;
   localparam int FRAMER_LOSS_BIT    = 19;

   // Bits that latch; the others follow their source
   localparam logic [23:0] STICKY_BITS = 24'h38FFFF;

   // ****************************************************************
   // Line monitor counts and times
   // ****************************************************************
   localparam int CLK_PERIOD_NS  = 10;
   localparam int ZERO_RUN_EIGHT = 8;
   localparam int ZERO_RUN_SIXTEEN = 16;
   localparam int ZERO_RUN_LOSS  = 192;
   localparam int ONES_WINDOW    = 112;
   localparam int ONES_NEEDED    = 14;
   localparam int CLK_LOSS_NS    = 2000;
   localparam int CLK_LOSS_CYC   =
      (CLK_LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BLUE_WIN_NS    = 3000000;
   localparam int BLUE_WIN_CYC   = BLUE_WIN_NS / CLK_PERIOD_NS;
   localparam int BLUE_ZERO_MIN  = 6;

   // ****************************************************************
   // Event inputs from the framer, stores and line interface
   // ****************************************************************
   typedef struct packed {
      logic       align_change;
      logic       rx_store_full;
      logic       rx_store_empty;
      logic       severe_framing_err;
      logic       framing_bit_err;
      logic       code_word;
      logic       sync_lost;
      logic       carrier_lost;
      logic       tx_store_full;
      logic       tx_store_empty;
      logic       rx_density_bad;
      logic       tx_density_bad;
      logic       jitter_near_limit;
      logic [1:0] level_code;
   } trir_evt_s;

endpackage

/* File: hw/trir_regs.sv */
`timescale 1ns/1ns
// Overview of operation
// RULE_01: Latch alignment-change flag, bit 7 of info one, after resync moves.
// RULE_02: Latch eight-zero flag, bit 6, on eight or more zeros in a row.
// RULE_03: Latch sixteen-zero flag, bit 5, on sixteen or more zeros.
// RULE_04: Latch transmit store full, info two bit 5, when a frame is dropped.
// RULE_05: Latch transmit store empty, bit 4, when a frame is repeated.
// RULE_06: Latch transmit slip, bit 3, on either repeat or deletion.
// RULE_07: Set sync-recovered, info two bit 7, when framer regains sync.
// RULE_08: Set carrier-restored, bit 6, when line carrier loss ends.
// RULE_09: Set all-ones-cleared, bit 2, when unframed all-ones stops.
// RULE_10: Latch receive density violation at bit 1.
// RULE_11: Latch transmit density violation at bit 0.
// RULE_12: Latch jitter-limit, info three bit 5, near attenuator capacity.
// RULE_13: Latch receive clock loss, bit 4, after 2 us without transition.
// RULE_14: Set framer carrier loss, bit 3, after 192 consecutive zeros.
// RULE_15: Clear framer carrier loss only on 14 ones within 112 bits.
// RULE_16: Report receive level code in info three bits 7:6.
// RULE_17: Info three bits 2:0 are unassigned; host ignores them.
// RULE_18: Level code upper bit sits at 7, lower bit at 6.
// RULE_19: Latch receive store full and empty at info one bits 4 and 3.
// RULE_20: Latch severe framing at bit 2 and framing bit error at bit 0.
// RULE_21: Latch code word detect at bit 1 regardless of decoding.
// RULE_22: Flags hold until read, then clear unless still present.
// RULE_23: Mask write selects bits to update; others hold; write back clears.
// RULE_24: All-ones ends on six or more zeros within a 3 ms window.

module trir_regs
   import trir_pkg::*;
#(
   parameter int unsigned BLUE_WIN = BLUE_WIN_CYC
)
(
   input  wire logic       REF_CLK,
   input  wire logic       RST_N,
   input  wire logic [7:0] CP_ADDR,
   input  wire logic [7:0] CP_WDATA,
   input  wire logic       CP_WR,
   input  wire logic       CP_RD,
   output logic      [7:0] CP_RDATA,
   input  wire logic       RX_POS_DATA_IN,
   input  wire logic       RX_NEG_DATA_IN,
   input  wire logic       RX_CLOCK_IN,
   input  wire trir_evt_s  EVENTS
);

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [2:0] pin_s1_q;
   logic [2:0] pin_s2_q;
   logic       clk_prev_q;

   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         pin_s1_q   <= 3'h0;
         pin_s2_q   <= 3'h0;
         clk_prev_q <= 1'b0;
      end
      else
      begin
         pin_s1_q   <= {RX_CLOCK_IN, RX_NEG_DATA_IN, RX_POS_DATA_IN};
         pin_s2_q   <= pin_s1_q;
         clk_prev_q <= pin_s2_q[2];
      end
   end

   wire logic rx_edge  = pin_s2_q[2] & ~clk_prev_q;
   wire logic rx_trans = pin_s2_q[2] ^ clk_prev_q;
   wire logic rx_zero  = ~(pin_s2_q[0] | pin_s2_q[1]);
   wire logic rx_bit0  = rx_edge & rx_zero;
   wire logic rx_bit1  = rx_edge & ~rx_zero;

   // ****************************************************************
   // Zero runs and framer carrier loss
   // ****************************************************************
   logic [7:0] zero_run_q;
   logic       carrier_loss_q;
   logic       win_act_q;
   logic [6:0] win_pos_q;
   logic [3:0] win_ones_q;

   wire logic hit_eight   = rx_bit0 & (zero_run_q == 8'(ZERO_RUN_EIGHT - 1));
   wire logic hit_sixteen =
      rx_bit0 & (zero_run_q == 8'(ZERO_RUN_SIXTEEN - 1));
   wire logic hit_loss    = rx_bit0 & (zero_run_q == 8'(ZERO_RUN_LOSS - 1));
   wire logic run_full    = (zero_run_q == 8'(ZERO_RUN_LOSS));
   wire logic ones_done   =
      rx_bit1 & win_act_q & (win_ones_q == 4'(ONES_NEEDED - 1));
   wire logic win_last    = win_pos_q == 7'(ONES_WINDOW - 1);

   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
         zero_run_q <= 8'h00;
      else if (rx_bit1)
         zero_run_q <= 8'h00;
      else if (rx_bit0 && !run_full)
         zero_run_q <= zero_run_q + 8'h01;
   end

   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         carrier_loss_q <= 1'b0;
         win_act_q      <= 1'b0;
         win_pos_q      <= 7'h00;
         win_ones_q     <= 4'h0;
      end
      else if (hit_loss)
      begin
         carrier_loss_q <= 1'b1;                              // [RULE_14]
         win_act_q      <= 1'b0;
      end
      else if (carrier_loss_q && rx_edge)
      begin
         if (!win_act_q)
         begin
            win_act_q  <= rx_bit1;          // Window opens on first one
            win_pos_q  <= 7'h01;
            win_ones_q <= 4'h1;
         end
         else if (ones_done)
         begin
            carrier_loss_q <= 1'b0;                           // [RULE_15]
            win_act_q      <= 1'b0;
         end
         else
         begin
            win_act_q  <= !win_last;                          // [RULE_15]
            win_pos_q  <= win_pos_q + 7'h01;
            win_ones_q <= win_ones_q + {3'h0, rx_bit1};
         end
      end
   end

   // ****************************************************************
   // Receive clock loss
   // ****************************************************************
   logic [7:0] idle_q;

   wire logic clk_loss_hit =
      ~rx_trans & (idle_q == 8'(CLK_LOSS_CYC - 1));

   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N || rx_trans)
         idle_q <= 8'h00;
      else if (idle_q != 8'(CLK_LOSS_CYC))
         idle_q <= idle_q + 8'h01;
   end

   // ****************************************************************
   // Unframed all-ones monitor
   // ****************************************************************
   logic [18:0] bwin_q;
   logic [2:0]  bzero_q;
   logic        all_ones_q;

   wire logic bwin_end  = bwin_q == 19'(BLUE_WIN - 1);
   wire logic bzero_ok  = bzero_q == 3'(BLUE_ZERO_MIN);
   wire logic ones_gone = bwin_end & all_ones_q & bzero_ok;

   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         bwin_q     <= 19'h00000;
         bzero_q    <= 3'h0;
         all_ones_q <= 1'b0;
      end
      else if (bwin_end)
      begin
         bwin_q     <= 19'h00000;
         bzero_q    <= 3'h0;
         all_ones_q <= !bzero_ok;                             // [RULE_24]
      end
      else
      begin
         bwin_q <= bwin_q + 19'h00001;
         if (rx_bit0 && !bzero_ok)
            bzero_q <= bzero_q + 3'h1;
      end
   end

   // ****************************************************************
   // Level edges of framer and line interface
   // ****************************************************************
   logic sync_lost_q;
   logic carrier_lost_q;

   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         sync_lost_q    <= 1'b0;
         carrier_lost_q <= 1'b0;
      end
      else
      begin
         sync_lost_q    <= EVENTS.sync_lost;
         carrier_lost_q <= EVENTS.carrier_lost;
      end
   end

   // ****************************************************************
   // Flag sources
   // ****************************************************************
   logic [23:0] set_vec;

   always_comb
   begin
      set_vec                      = 24'h000000;
      set_vec[ALIGN_CHANGE_BIT]    = EVENTS.align_change;       // [RULE_01]
      set_vec[EIGHT_ZERO_BIT]      = hit_eight;                 // [RULE_02]
      set_vec[SIXTEEN_ZERO_BIT]    = hit_sixteen;               // [RULE_03]
      set_vec[RX_STORE_FULL_BIT]   = EVENTS.rx_store_full;      // [RULE_19]
      set_vec[RX_STORE_EMPTY_BIT]  = EVENTS.rx_store_empty;     // [RULE_19]
      set_vec[SEVERE_FRAME_BIT]    = EVENTS.severe_framing_err; // [RULE_20]
      set_vec[CODE_WORD_BIT]       = EVENTS.code_word;          // [RULE_21]
      set_vec[FRAMING_ERR_BIT]     = EVENTS.framing_bit_err;    // [RULE_20]
      set_vec[SYNC_RECOVER_BIT]    =
         sync_lost_q & ~EVENTS.sync_lost;                       // [RULE_07]
      set_vec[CARRIER_RESTORE_BIT] =
         carrier_lost_q & ~EVENTS.carrier_lost;                 // [RULE_08]
      set_vec[TX_STORE_FULL_BIT]   = EVENTS.tx_store_full;      // [RULE_04]
      set_vec[TX_STORE_EMPTY_BIT]  = EVENTS.tx_store_empty;     // [RULE_05]
      set_vec[TX_SLIP_BIT]         =
         EVENTS.tx_store_full | EVENTS.tx_store_empty;          // [RULE_06]
      set_vec[ALL_ONES_CLR_BIT]    = ones_gone;                 // [RULE_09]
      set_vec[RX_DENSITY_BIT]      = EVENTS.rx_density_bad;     // [RULE_10]
      set_vec[TX_DENSITY_BIT]      = EVENTS.tx_density_bad;     // [RULE_11]
      set_vec[LEVEL_HI_BIT]        = EVENTS.level_code[1];      // [RULE_18]
      set_vec[LEVEL_LO_BIT]        = EVENTS.level_code[0];      // [RULE_16]
      set_vec[JITTER_LIMIT_BIT]    = EVENTS.jitter_near_limit;  // [RULE_12]
      set_vec[RX_CLK_LOSS_BIT]     = clk_loss_hit;              // [RULE_13]
      set_vec[FRAMER_LOSS_BIT]     = carrier_loss_q;            // [RULE_14]
   end

   // ****************************************************************
   // Control port decode
   // ****************************************************************
   wire logic [2:0] reg_sel = {CP_ADDR == ADDR_INFO_THREE,
                               CP_ADDR == ADDR_INFO_TWO,
                               CP_ADDR == ADDR_INFO_ONE};
   wire logic [2:0] wr_sel  = reg_sel & {3{CP_WR}};
   wire logic [2:0] rd_sel  = reg_sel & {3{CP_RD}};

   // ****************************************************************
   // Per-bit flag, mask and snapshot
   // ****************************************************************
   logic [23:0] flag_q;
   logic [23:0] mask_q;
   logic [23:0] shown_q;

   for (genvar i = 0; i < 24; i++)
   begin : g_bit
      localparam int K = i / 8;
      wire logic clr   = rd_sel[K] & mask_q[i] & shown_q[i];
      wire logic held  = flag_q[i] & ~clr;
      wire logic upd   = wr_sel[K] & CP_WDATA[i % 8];

      always_ff @(posedge REF_CLK)
      begin
         if (!RST_N)
         begin
            flag_q[i]  <= INFO_RESET[i % 8];
            mask_q[i]  <= INFO_RESET[i % 8];
            shown_q[i] <= INFO_RESET[i % 8];
         end
         else
         begin
            // Set beats the read clear in the same cycle
            flag_q[i] <= STICKY_BITS[i] ?
                         (set_vec[i] | held) : set_vec[i];      // [RULE_22]
            if (wr_sel[K])
               mask_q[i] <= CP_WDATA[i % 8];                    // [RULE_23]
            if (upd)
               shown_q[i] <= flag_q[i];                         // [RULE_23]
         end
      end
   end

   // ****************************************************************
   // Read data
   // ****************************************************************
   logic [7:0] rdata_q;

   wire logic [7:0] rdata_d =
      rd_sel[0] ? shown_q[7:0] :
      rd_sel[1] ? shown_q[15:8] :
      rd_sel[2] ? {shown_q[23:19], 3'h0} :                      // [RULE_17]
                  RDATA_UNMAPPED;

   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
         rdata_q <= RDATA_UNMAPPED;
      else if (CP_RD)
         rdata_q <= rdata_d;
   end

   assign CP_RDATA = rdata_q;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RST_N);

   sequence s_mask_one;
      CP_WR && reg_sel[0];
   endsequence

   sequence s_read_one;
      CP_RD && reg_sel[0];
   endsequence

   a_eight_zero: assert property (                              // [RULE_02]
      hit_eight |=> flag_q[EIGHT_ZERO_BIT])
      else $error("eight-zero flag not latched");
   a_sixteen_zero: assert property (                            // [RULE_03]
      hit_sixteen |=> flag_q[SIXTEEN_ZERO_BIT])
      else $error("sixteen-zero flag not latched");
   a_tx_slip_set: assert property (                             // [RULE_06]
      (EVENTS.tx_store_full || EVENTS.tx_store_empty) |=>
         flag_q[TX_SLIP_BIT])
      else $error("transmit slip not latched");

   a_sync_recover: assert property (                            // [RULE_07]
      $fell(EVENTS.sync_lost) |=> flag_q[SYNC_RECOVER_BIT])
      else $error("sync recovered not set");
   a_loss_on_run: assert property (                             // [RULE_14]
      hit_loss |=> carrier_loss_q ##1 flag_q[FRAMER_LOSS_BIT])
      else $error("carrier loss not set after zero run");
   a_loss_release: assert property (                            // [RULE_15]
      $fell(carrier_loss_q) |-> $past(win_ones_q) == 4'(ONES_NEEDED - 1))
      else $error("carrier loss cleared without enough ones");

   a_clk_loss: assert property (                                // [RULE_13]
      clk_loss_hit |=> flag_q[RX_CLK_LOSS_BIT] && idle_q != 8'h00)
      else $error("receive clock loss not latched");
   a_level_live: assert property (                              // [RULE_16]
      ##1 flag_q[23:22] == $past(EVENTS.level_code))
      else $error("level code not following input");

   a_mask_hold: assert property (                               // [RULE_23]
      s_mask_one |=> (shown_q[7:0] & ~$past(CP_WDATA)) ==
         ($past(shown_q[7:0]) & ~$past(CP_WDATA)))
      else $error("unmasked bit changed on mask write");
   a_read_clear: assert property (                              // [RULE_22]
      s_read_one and (mask_q[ALIGN_CHANGE_BIT] && shown_q[ALIGN_CHANGE_BIT]
      && !EVENTS.align_change) |=> !flag_q[ALIGN_CHANGE_BIT])
      else $error("flag not cleared by read");

   a_read_data: assert property (                               // [RULE_23]
      s_read_one |=> CP_RDATA == $past(shown_q[7:0]))
      else $error("read data not the snapshot");

   a_ones_gone: assert property (                               // [RULE_09]
      ones_gone |=> !all_ones_q && flag_q[ALL_ONES_CLR_BIT])
      else $error("all-ones clear not reported");

endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/1ns
`define CHK(n, e, g) \
   begin \
      cmp_count++; \
      if ((g) !== (e)) \
      begin \
         mismatches++; \
         $display("Error %s expected %h seen %h", n, e, g); \
      end \
   end

module tb_top;
   import trir_pkg::*;

   logic        ref_clk;
   logic        rst_n;
   logic [7:0]  cp_addr;
   logic [7:0]  cp_wdata;
   logic        cp_wr;
   logic        cp_rd;
   logic [7:0]  cp_rdata;
   logic        rx_pos;
   logic        rx_neg;
   logic        rx_clk;
   logic        pol;
   logic [14:0] ev_q;
   trir_evt_s   events;
   int          mismatches;
   int          cmp_count;
   int          k;
   int          r;
   logic [31:0] seed;
   logic [7:0]  m;
   logic [7:0]  lb;
   logic [1:0]  lvl;
   int          src_b [11] = '{14, 13, 12, 11, 10, 9, 6, 5, 4, 3, 2};
   int          dst_b [11] = '{ALIGN_CHANGE_BIT, RX_STORE_FULL_BIT,
      RX_STORE_EMPTY_BIT, SEVERE_FRAME_BIT, FRAMING_ERR_BIT, CODE_WORD_BIT,
      TX_STORE_FULL_BIT, TX_STORE_EMPTY_BIT, RX_DENSITY_BIT, TX_DENSITY_BIT,
      JITTER_LIMIT_BIT};

   assign events = trir_evt_s'(ev_q);

   trir_regs #(.BLUE_WIN(500)) i_trir_regs
   (
      .REF_CLK        (ref_clk),
      .RST_N          (rst_n),
      .CP_ADDR        (cp_addr),
      .CP_WDATA       (cp_wdata),
      .CP_WR          (cp_wr),
      .CP_RD          (cp_rd),
      .CP_RDATA       (cp_rdata),
      .RX_POS_DATA_IN (rx_pos),
      .RX_NEG_DATA_IN (rx_neg),
      .RX_CLOCK_IN    (rx_clk),
      .EVENTS         (events)
   );

   always #5 ref_clk = ~ref_clk;

   // ****************************************************************
   // Bus cycles and helpers
   // ****************************************************************
   task step;
      @(posedge ref_clk);
      #1;
   endtask

   function automatic logic [31:0] nxt(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task cp_write(input logic [7:0] a, input logic [7:0] d);
      cp_addr = a;
      cp_wdata = d;
      cp_wr = 1'b1;
      step;
      cp_wr = 1'b0;
   endtask

   task cp_read(input logic [7:0] a, output logic [7:0] d);
      cp_addr = a;
      cp_rd = 1'b1;
      step;
      cp_rd = 1'b0;
      step;
      d = cp_rdata;
   endtask

   // Mask write, read, clearing write-back
   task poll(input logic [7:0] a, input logic [7:0] mk,
         output logic [7:0] d);
      cp_write(a, mk);
      cp_read(a, d);
      cp_write(a, d & mk);
      step;
   endtask

   task automatic expect_reg(input string n, input logic [7:0] a,
         input logic [7:0] mk, input logic [7:0] e);
      logic [7:0] v;
      poll(a, mk, v);
      `CHK(n, e & mk, v & mk)
   endtask

   task pulse(input int b);
      ev_q[b] = 1'b1;
      step;
      ev_q[b] = 1'b0;
   endtask

   // Line bits, alternating rails for ones
   task send_bits(input int n, input logic v);
      repeat (n)
      begin
         rx_pos = v & pol;
         rx_neg = v & ~pol;
         pol = pol ^ v;
         rx_clk = 1'b0;
         repeat (8) step;
         rx_clk = 1'b1;
         repeat (8) step;
      end
   endtask

   function automatic logic [7:0] addr_of(input int rg);
      return (rg == 0) ? ADDR_INFO_ONE :
             (rg == 1) ? ADDR_INFO_TWO : ADDR_INFO_THREE;
   endfunction

   function automatic logic [7:0] exp_byte(input int kk, input int rg);
      logic [23:0] v;
      v = 24'h000001 << dst_b[kk];
      if (src_b[kk] == 6 || src_b[kk] == 5)
      begin
         v[TX_SLIP_BIT] = 1'b1;
      end
      return v[8*rg +: 8];
   endfunction

   task finish_test;
      $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial
   begin
      repeat (100000) @(posedge ref_clk);
      mismatches++;
      finish_test;
   end

   initial
   begin
      ref_clk = 1'b0;
      rst_n = 1'b0;
      cp_addr = 8'h00;
      cp_wdata = 8'h00;
      cp_wr = 1'b0;
      cp_rd = 1'b0;
      rx_pos = 1'b0;
      rx_neg = 1'b0;
      rx_clk = 1'b0;
      pol = 1'b1;
      ev_q = 15'h0000;
      mismatches = 0;
      cmp_count = 0;
      seed = 32'd92;
      repeat (3) @(posedge ref_clk);
      #1;
      rst_n = 1'b1;
      step;
      expect_reg("reset one", ADDR_INFO_ONE, 8'hFF, INFO_RESET);
      expect_reg("reset two", ADDR_INFO_TWO, 8'hFF, INFO_RESET);
      expect_reg("reset three", ADDR_INFO_THREE, 8'hF8, INFO_RESET);
      $display("Test reset done");

      for (int i = 0; i < 24; i++)
      begin
         seed = nxt(seed);
         k = int'(seed % 32'd11);
         lvl = seed[9:8];
         m = seed[23:16] | (8'h01 << (dst_b[k] % 8));
         r = dst_b[k] / 8;
         if (r == 1) m = m | 8'h08;
         if (r == 2) m = m & 8'hE0;
         ev_q[1:0] = lvl;
         pulse(src_b[k]);
         repeat (2) step;
         lb = (r == 2) ? {lvl, 6'h00} : 8'h00;
         expect_reg("event flag", addr_of(r), m, exp_byte(k, r) | lb);
         expect_reg("event clear", addr_of(r), m, lb);
      end
      $display("Test events done");

      expect_reg("mask prep", ADDR_INFO_ONE, 8'hFF, 8'h00);
      pulse(14);
      repeat (2) step;
      poll(ADDR_INFO_ONE, 8'h7F, m);
      `CHK("mask held", 8'h00, m)
      expect_reg("mask kept", ADDR_INFO_ONE, 8'h80, 8'h80);
      expect_reg("mask clear", ADDR_INFO_ONE, 8'h80, 8'h00);
      $display("Test mask done");

      for (int j = 0; j < 2; j++)
      begin
         m = (j == 0) ? 8'h80 : 8'h40;
         ev_q[8 - j] = 1'b1;
         repeat (5) step;
         expect_reg("restore idle", ADDR_INFO_TWO, m, 8'h00);
         ev_q[8 - j] = 1'b0;
         repeat (2) step;
         expect_reg("restore set", ADDR_INFO_TWO, m, m);
         expect_reg("restore clr", ADDR_INFO_TWO, m, 8'h00);
      end
      $display("Test restore done");

      send_bits(40, 1'b1);
      expect_reg("zero prep", ADDR_INFO_ONE, 8'h60, 8'h00);
      send_bits(7, 1'b0);
      send_bits(1, 1'b1);
      expect_reg("zero seven", ADDR_INFO_ONE, 8'h60, 8'h00);
      send_bits(8, 1'b0);
      send_bits(1, 1'b1);
      expect_reg("zero eight", ADDR_INFO_ONE, 8'h60, 8'h40);
      send_bits(16, 1'b0);
      send_bits(1, 1'b1);
      expect_reg("zero sixteen", ADDR_INFO_ONE, 8'h60, 8'h60);
      $display("Test zeros done");

      // Receive clock idle from reset until the zero tests has latched the loss flag
      expect_reg("clk prep", ADDR_INFO_THREE, 8'h10, 8'h10);
      repeat (140) step;
      expect_reg("clk early", ADDR_INFO_THREE, 8'h10, 8'h00);
      repeat (100) step;
      expect_reg("clk lost", ADDR_INFO_THREE, 8'h10, 8'h10);
      $display("Test clock done");

      send_bits(191, 1'b0);
      expect_reg("loss early", ADDR_INFO_THREE, 8'h08, 8'h00);
      send_bits(1, 1'b0);
      expect_reg("loss set", ADDR_INFO_THREE, 8'h08, 8'h08);
      expect_reg("loss held", ADDR_INFO_THREE, 8'h08, 8'h08);
      repeat (13)
      begin
         send_bits(1, 1'b1);
         send_bits(1, 1'b0);
      end
      send_bits(100, 1'b0);
      expect_reg("loss few", ADDR_INFO_THREE, 8'h08, 8'h08);
      send_bits(14, 1'b1);
      expect_reg("loss last", ADDR_INFO_THREE, 8'h08, 8'h08);
      expect_reg("loss gone", ADDR_INFO_THREE, 8'h08, 8'h00);
      $display("Test framer loss done");

      send_bits(80, 1'b1);
      poll(ADDR_INFO_TWO, 8'h04, m);
      expect_reg("ones active", ADDR_INFO_TWO, 8'h04, 8'h00);
      send_bits(80, 1'b0);
      expect_reg("ones clear", ADDR_INFO_TWO, 8'h04, 8'h04);
      expect_reg("ones read", ADDR_INFO_TWO, 8'h04, 8'h00);
      $display("Test all ones done");

      cp_write(8'h55, 8'hFF);
      step;
      expect_reg("unmapped", 8'h55, 8'hFF, RDATA_UNMAPPED);
      $display("Test unmapped done");
      finish_test;
   end
endmodule
